// ---- rtl/srcc_defines.vh ----
`ifndef SRCC_DEFINES_VH
`define SRCC_DEFINES_VH

// Command codes presented by the parser
`define SRCC_CMD_CLS    4'h0
`define SRCC_CMD_ESE    4'h1
`define SRCC_CMD_ESE_Q  4'h2
`define SRCC_CMD_ESR_Q  4'h3
`define SRCC_CMD_IDN_Q  4'h4
`define SRCC_CMD_OPC    4'h5
`define SRCC_CMD_OPC_Q  4'h6
`define SRCC_CMD_RST    4'h7
`define SRCC_CMD_STB_Q  4'h8
`define SRCC_CMD_SRE    4'h9
`define SRCC_CMD_SRE_Q  4'hA

// Status summary byte bit positions
`define SRCC_STB_OUT_PEND  4
`define SRCC_STB_EVT_SUM   5
`define SRCC_STB_MASTER    6

// Event register bit positions
`define SRCC_EVT_OPC  0
`define SRCC_EVT_QYE  2
`define SRCC_EVT_DDE  3
`define SRCC_EVT_EXE  4
`define SRCC_EVT_CME  5
`define SRCC_EVT_PON  7

// Masks and reset values
`define SRCC_SRE_USED   8'hBF
`define SRCC_SUM_USED   8'hBE
`define SRCC_EVT_USED   8'hBD
`define SRCC_EVT_RESET  8'h80
`define SRCC_MASK_RESET 8'h00
`define SRCC_VAL_MAX    16'h00FF

// Response characters
`define SRCC_ASCII_ZERO 8'h30
`define SRCC_ASCII_ONE  8'h01
`define SRCC_TERM_CHAR  8'h0A
`define SRCC_IDN_LEN    29
`define SRCC_IDN_LAST   5'h1C

`endif

// ---- rtl/srcc_dec_fmt.v ----
`timescale 1ns/1ps
`include "srcc_defines.vh"
module srcc_dec_fmt (
  // Binary value
  input  wire [7:0] value,
  // Decimal digits as ASCII, and how many of them are used
  output wire [7:0] char_h,
  output wire [7:0] char_t,
  output wire [7:0] char_o,
  output wire [1:0] ndig
);
  wire [7:0] hun;
  wire [7:0] rem;
  wire [7:0] ten;
  wire [7:0] one;

  assign hun    = value / 8'h64;
  assign rem    = value % 8'h64;
  assign ten    = rem / 8'h0A;
  assign one    = value % 8'h0A;
  assign char_h = `SRCC_ASCII_ZERO + hun;
  assign char_t = `SRCC_ASCII_ZERO + ten;
  assign char_o = `SRCC_ASCII_ZERO + one;
  // No leading zeros; zero itself is one digit
  assign ndig   = (hun != 8'h00) ? 2'h3 : ((ten != 8'h00) ? 2'h2 : 2'h1);
endmodule

// ---- rtl/srcc_core.v ----
`timescale 1ns/1ps
`include "srcc_defines.vh"
module srcc_core #(
  // Identity text of exactly 29 characters: maker,model,serial,versions (four fields)
  parameter [8*`SRCC_IDN_LEN-1:0] IDN_TEXT = "VENDOR,MODELX,0000000,1.0/1.0"
) (
  // Clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // Decoded commands from the parser
  input  wire        cmd_valid,
  input  wire [3:0]  cmd_code,
  input  wire [15:0] cmd_value,
  input  wire        cmd_first,
  input  wire        cmd_bad,
  // Other event sources
  input  wire        qye_evt,
  input  wire        dde_evt,
  input  wire        panel_srq,
  // Serial poll
  input  wire        poll_req,
  output reg  [7:0]  poll_data_q,
  output reg         poll_valid_q,
  // Response characters to the serial transmitter
  input  wire        resp_ready,
  output reg  [7:0]  resp_data_q,
  output reg         resp_valid_q,
  output reg         resp_last_q,
  // Status view
  output reg  [7:0]  status_summary_byte_q,
  output reg         service_request_flag_q
);
  localparam S_IDLE = 4'b0001;
  localparam S_NUM  = 4'b0010;
  localparam S_IDN  = 4'b0100;
  localparam S_TERM = 4'b1000;

  reg  [3:0] state_q;
  reg  [7:0] event_register_q;
  reg  [7:0] event_mask_register_q;
  reg  [7:0] service_enable_mask_q;
  reg        output_pending_bit_q;
  reg  [7:0] num_q;
  reg  [4:0] pos_q;
  reg  [2:0] srq_sync_q;
  reg        srq_lvl_q;
  reg  [7:0] qval;
  reg        qnum;
  reg  [7:0] num_char;

  wire       event_summary_bit;
  wire [7:0] stb_base;
  wire       master_summary_bit;
  wire [7:0] stb;
  wire       ok;
  wire       in_range;
  wire       is_query;
  wire       qidn;
  wire       busy;
  wire       resp_fire;
  wire [7:0] evt_set;
  wire       esr_clr;
  wire       flush;
  wire [7:0] d_h;
  wire [7:0] d_t;
  wire [7:0] d_o;
  wire [1:0] ndig;
  wire [1:0] dsel;
  wire [7:0] idn_char;
  wire       num_last;
  wire       idn_last;

  assign event_summary_bit  = |(event_register_q & event_mask_register_q);
  assign stb_base           = {2'b00, event_summary_bit, output_pending_bit_q, 4'h0};
  assign master_summary_bit = |(stb_base & service_enable_mask_q & `SRCC_SUM_USED);
  assign stb                = stb_base | {1'b0, master_summary_bit, 6'b000000};
  assign ok                 = cmd_valid & ~cmd_bad;
  assign in_range           = (cmd_value <= `SRCC_VAL_MAX);
  assign qidn               = (cmd_code == `SRCC_CMD_IDN_Q);
  assign is_query           = qnum | qidn;
  assign busy               = ~state_q[0];
  assign resp_fire          = resp_valid_q & resp_ready;
  assign flush              = ok & (cmd_code == `SRCC_CMD_CLS) & cmd_first;
  // A refused event query keeps its events
  assign esr_clr            = ok & (((cmd_code == `SRCC_CMD_ESR_Q) & ~busy) |
                                    (cmd_code == `SRCC_CMD_CLS));

  // Event sources; bits 1 and 6 never set
  assign evt_set[`SRCC_EVT_OPC] = ok & (cmd_code == `SRCC_CMD_OPC);
  assign evt_set[1]             = 1'b0;
  assign evt_set[`SRCC_EVT_QYE] = qye_evt | (ok & is_query & busy);
  assign evt_set[`SRCC_EVT_DDE] = dde_evt;
  assign evt_set[`SRCC_EVT_EXE] = ok & ~in_range & ((cmd_code == `SRCC_CMD_ESE) |
                                                    (cmd_code == `SRCC_CMD_SRE));
  assign evt_set[`SRCC_EVT_CME] = cmd_valid & cmd_bad;
  assign evt_set[6]             = 1'b0;
  assign evt_set[`SRCC_EVT_PON] = 1'b0;

  // Query values, sampled when the query is taken
  always @* begin
    qval = 8'h00;
    qnum = 1'b1;
    case (cmd_code)
      `SRCC_CMD_STB_Q: qval = stb;
      `SRCC_CMD_ESE_Q: qval = event_mask_register_q;
      `SRCC_CMD_ESR_Q: qval = event_register_q & `SRCC_EVT_USED;
      `SRCC_CMD_SRE_Q: qval = service_enable_mask_q & `SRCC_SRE_USED;
      `SRCC_CMD_OPC_Q: qval = `SRCC_ASCII_ONE;
      default:         qnum = 1'b0;
    endcase
  end

  srcc_dec_fmt u_fmt (
    .value  (num_q),
    .char_h (d_h),
    .char_t (d_t),
    .char_o (d_o),
    .ndig   (ndig)
  );

  assign dsel     = pos_q[1:0] + (2'h3 - ndig);
  assign num_last = (pos_q == {3'b000, ndig - 2'h1});
  assign idn_char = IDN_TEXT[(`SRCC_IDN_LEN - 1 - pos_q) * 8 +: 8];
  assign idn_last = (pos_q == `SRCC_IDN_LAST);

  always @* begin
    case (dsel)
      2'h0:    num_char = d_h;
      2'h1:    num_char = d_t;
      default: num_char = d_o;
    endcase
  end

  // Same values for power-up and for the reset command
  task power_up;
    begin
      state_q                <= S_IDLE;
      event_register_q       <= `SRCC_EVT_RESET;
      event_mask_register_q  <= `SRCC_MASK_RESET;
      service_enable_mask_q  <= `SRCC_MASK_RESET;
      output_pending_bit_q   <= 1'b0;
      num_q                  <= 8'h00;
      pos_q                  <= 5'h00;
      resp_data_q            <= 8'h00;
      resp_valid_q           <= 1'b0;
      resp_last_q            <= 1'b0;
      poll_data_q            <= 8'h00;
      poll_valid_q           <= 1'b0;
      status_summary_byte_q  <= 8'h00;
      service_request_flag_q <= 1'b0;
    end
  endtask

  // Panel pin filter; first stage feeds only the second
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      srq_sync_q <= 3'b000;
      srq_lvl_q  <= 1'b0;
    end else begin
      srq_sync_q <= {srq_sync_q[1:0], panel_srq};
      if (srq_sync_q[1] == srq_sync_q[2]) begin
        srq_lvl_q <= srq_sync_q[2];
      end
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      power_up;
    end else if (ok & (cmd_code == `SRCC_CMD_RST)) begin
      power_up;
    end else begin
      status_summary_byte_q <= stb;
      poll_valid_q          <= poll_req;
      if (poll_req) begin
        poll_data_q <= {stb[7], service_request_flag_q, stb[5:0]};
      end
      // New request wins over the poll's clear
      service_request_flag_q <= (service_request_flag_q & ~poll_req) |
                                srq_lvl_q | master_summary_bit;
      event_register_q <= (esr_clr ? 8'h00 : event_register_q) | evt_set;
      if (ok & in_range & (cmd_code == `SRCC_CMD_ESE)) begin
        event_mask_register_q <= cmd_value[7:0];
      end
      if (ok & in_range & (cmd_code == `SRCC_CMD_SRE)) begin
        service_enable_mask_q <= cmd_value[7:0] & `SRCC_SRE_USED;
      end
      if (flush) begin
        // Drops an unsent reply mid-stream
        state_q              <= S_IDLE;
        resp_valid_q         <= 1'b0;
        resp_last_q          <= 1'b0;
        output_pending_bit_q <= 1'b0;
      end else begin
        case (state_q)
          S_IDLE: begin
            if (ok & is_query) begin
              num_q                <= qval;
              pos_q                <= 5'h00;
              output_pending_bit_q <= 1'b1;
              state_q              <= qidn ? S_IDN : S_NUM;
            end
          end
          S_NUM: begin
            if (!resp_valid_q) begin
              resp_data_q  <= num_char;
              resp_valid_q <= 1'b1;
            end else if (resp_fire) begin
              resp_valid_q <= 1'b0;
              pos_q        <= pos_q + 5'h01;
              if (num_last) begin
                state_q <= S_TERM;
              end
            end
          end
          S_IDN: begin
            if (!resp_valid_q) begin
              resp_data_q  <= idn_char;
              resp_valid_q <= 1'b1;
            end else if (resp_fire) begin
              resp_valid_q <= 1'b0;
              pos_q        <= pos_q + 5'h01;
              if (idn_last) begin
                state_q <= S_TERM;
              end
            end
          end
          S_TERM: begin
            if (!resp_valid_q) begin
              resp_data_q  <= `SRCC_TERM_CHAR;
              resp_valid_q <= 1'b1;
              resp_last_q  <= 1'b1;
            end else if (resp_fire) begin
              resp_valid_q         <= 1'b0;
              resp_last_q          <= 1'b0;
              output_pending_bit_q <= 1'b0;
              state_q              <= S_IDLE;
            end
          end
          default: state_q <= S_IDLE;
        endcase
      end
    end
  end
endmodule

// ---- test/srcc_core_asserts.sv ----
`timescale 1ns/1ps
module srcc_core_asserts (
  // Clock and reset
  input wire       clk,
  input wire       reset_n,
  // Command and poll side
  input wire       cmd_valid,
  input wire [3:0] cmd_code,
  input wire       cmd_bad,
  input wire       poll_req,
  input wire [7:0] poll_data_q,
  input wire       poll_valid_q,
  // Reply and status side
  input wire       resp_ready,
  input wire [7:0] resp_data_q,
  input wire       resp_valid_q,
  input wire       resp_last_q,
  input wire [7:0] status_summary_byte_q,
  input wire       service_request_flag_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  chk_unused_bits_zero: assert property (
    status_summary_byte_q[3:0] == 4'h0 && !status_summary_byte_q[7])
    else $error("reserved status bit set");
  chk_pending_while_reply: assert property (
    resp_valid_q |-> status_summary_byte_q[4])
    else $error("reply without pending bit");
  chk_pending_clears: assert property (
    resp_valid_q && resp_ready && resp_last_q |-> ##[1:2] !status_summary_byte_q[4])
    else $error("pending bit stuck after terminator");
  chk_master_sets_flag: assert property (
    status_summary_byte_q[6] |-> ##[0:2] service_request_flag_q)
    else $error("master summary did not set flag");
  chk_poll_answer: assert property (
    poll_req |=> poll_valid_q && poll_data_q[6] == $past(service_request_flag_q))
    else $error("poll answer wrong");
  chk_reply_holds: assert property (
    resp_valid_q && !resp_ready && !(cmd_valid && (cmd_code == 4'h0 || cmd_code == 4'h7))
    |=> resp_valid_q && $stable(resp_data_q))
    else $error("reply char dropped before accept");
  chk_reply_gap: assert property (
    resp_valid_q && resp_ready |=> !resp_valid_q)
    else $error("no idle cycle after accept");
  chk_reset_cmd: assert property (
    cmd_valid && cmd_code == 4'h7 && !cmd_bad
    |=> status_summary_byte_q == 8'h00 && !resp_valid_q)
    else $error("reset command left state");
endmodule

bind srcc_core srcc_core_asserts u_chk (.clk, .reset_n, .cmd_valid, .cmd_code, .cmd_bad, .poll_req,
  .poll_data_q, .poll_valid_q, .resp_ready, .resp_data_q, .resp_valid_q, .resp_last_q,
  .status_summary_byte_q, .service_request_flag_q);

// ---- test/srcc_host_model.sv ----
`timescale 1ns/1ps
module srcc_host_model (
  // Clock and reset
  input  wire        clk,
  input  wire        reset_n,
  // Pace: slow accepts one char in four
  input  wire        slow,
  // Reply stream
  input  wire [7:0]  resp_data_q,
  input  wire        resp_valid_q,
  input  wire        resp_last_q,
  output reg         resp_ready,
  // Decoded reply
  output reg  [15:0] rep_val,
  output reg  [7:0]  rep_len,
  output reg  [3:0]  rep_commas,
  output reg         rep_done
);
  reg [1:0] pace_q;
  reg       open_q;
  // Only digits build rep_val, so an identity reply also yields a number
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pace_q <= 2'h0;
      open_q <= 1'b0;
      resp_ready <= 1'b0;
      rep_val <= 16'h0000;
      rep_len <= 8'h00;
      rep_commas <= 4'h0;
      rep_done <= 1'b0;
    end else begin
      pace_q <= pace_q + 2'h1;
      resp_ready <= !slow || pace_q == 2'h3;
      rep_done <= 1'b0;
      if (resp_valid_q && resp_ready) begin
        if (resp_last_q) begin
          open_q <= 1'b0;
          rep_done <= 1'b1;
        end else begin
          open_q <= 1'b1;
          if (resp_data_q >= 8'h30 && resp_data_q <= 8'h39) begin
            rep_val <= (open_q ? rep_val * 16'h000A : 16'h0000) + {8'h00, resp_data_q - 8'h30};
          end else begin
            rep_val <= open_q ? rep_val : 16'h0000;
          end
          rep_len <= (open_q ? rep_len : 8'h00) + 8'h01;
          rep_commas <= (open_q ? rep_commas : 4'h0) + {3'h0, resp_data_q == 8'h2C};
        end
      end
    end
  end
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`include "srcc_defines.vh"
module tb_top;
  reg         clk, reset_n, cmd_valid, cmd_first, cmd_bad, qye_evt, dde_evt, panel_srq;
  reg         poll_req, slow;
  reg  [3:0]  cmd_code;
  reg  [15:0] cmd_value;
  wire [7:0]  poll_data_q, resp_data_q, status_summary_byte_q, rep_len;
  wire        poll_valid_q, resp_valid_q, resp_last_q, service_request_flag_q;
  wire        resp_ready, rep_done;
  wire [15:0] rep_val;
  wire [3:0]  rep_commas;
  integer     fail_count, num_checks, cycles;

  // Own identity text, so the reply's digits give a known value
  srcc_core #(.IDN_TEXT("NEUTRL,BOXMDL,0000000,0.1/0.2")) dut (
    .clk, .reset_n, .cmd_valid, .cmd_code, .cmd_value, .cmd_first, .cmd_bad,
    .qye_evt, .dde_evt, .panel_srq, .poll_req, .poll_data_q, .poll_valid_q, .resp_ready,
    .resp_data_q, .resp_valid_q, .resp_last_q, .status_summary_byte_q, .service_request_flag_q);
  srcc_host_model host (.clk, .reset_n, .slow, .resp_data_q, .resp_valid_q, .resp_last_q,
    .resp_ready, .rep_val, .rep_len, .rep_commas, .rep_done);

  task give_verdict;
    begin
      $display("checks=%0d fails=%0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #10;
    end
  endtask
  task cmd(input [3:0] c, input [15:0] v, input b, input f);
    begin
      cmd_code = c;
      cmd_value = v;
      cmd_bad = b;
      cmd_first = f;
      cmd_valid = 1'b1;
      tick(1);
      cmd_valid = 1'b0;
      tick(1);
    end
  endtask
  task query(input [3:0] c, input [15:0] exp);
    integer n;
    begin
      cmd(c, 16'h0000, 1'b0, 1'b0);
      n = 0;
      while (rep_done !== 1'b1 && n < 300) begin
        tick(1);
        n = n + 1;
      end
      chk({15'h0000, rep_done}, 16'h0001);
      chk(rep_val, exp);
    end
  endtask
  task poll(input [7:0] exp);
    begin
      poll_req = 1'b1;
      tick(1);
      poll_req = 1'b0;
      chk({poll_valid_q, poll_data_q}, {1'b1, exp});
      tick(1);
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard; the full sequence needs roughly 300 cycles
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      give_verdict;
    end
  end

  initial begin
    {reset_n, cmd_valid, cmd_first, cmd_bad, qye_evt, dde_evt} = 6'h00;
    {panel_srq, poll_req, slow} = 3'h0;
    cmd_code = 4'h0;
    cmd_value = 16'h0000;
    fail_count = 0;
    num_checks = 0;
    cycles = 0;
    tick(2);
    reset_n = 1'b1;
    query(`SRCC_CMD_ESR_Q, 16'd128);
    query(`SRCC_CMD_ESR_Q, 16'd0);
    cmd(`SRCC_CMD_ESE, 16'd5, 1'b0, 1'b0);
    query(`SRCC_CMD_ESE_Q, 16'd5);
    cmd(`SRCC_CMD_ESE, 16'd256, 1'b0, 1'b0);
    query(`SRCC_CMD_ESE_Q, 16'd5);
    query(`SRCC_CMD_ESR_Q, 16'd16);
    cmd(`SRCC_CMD_ESE, 16'd1, 1'b0, 1'b0);
    cmd(`SRCC_CMD_OPC, 16'd0, 1'b0, 1'b0);
    tick(2);
    chk(status_summary_byte_q, 8'h20);
    cmd(`SRCC_CMD_SRE, 16'd255, 1'b0, 1'b0);
    query(`SRCC_CMD_SRE_Q, 16'd191);
    tick(3);
    chk({service_request_flag_q, status_summary_byte_q}, 9'h160);
    query(`SRCC_CMD_STB_Q, 16'd96);
    tick(2);
    chk(status_summary_byte_q, 8'h60);
    cmd(`SRCC_CMD_SRE, 16'd0, 1'b0, 1'b0);
    tick(2);
    poll(8'h60);
    poll(8'h20);
    query(`SRCC_CMD_ESR_Q, 16'd1);
    tick(2);
    chk(status_summary_byte_q, 8'h00);
    query(`SRCC_CMD_OPC_Q, 16'd1);
    chk(rep_len, 8'd1);
    slow = 1'b1;
    query(`SRCC_CMD_IDN_Q, 16'd102);
    chk({rep_commas, rep_len}, {4'd3, 8'd29});
    slow = 1'b0;
    cmd(`SRCC_CMD_ESE, 16'd7, 1'b1, 1'b0);
    query(`SRCC_CMD_ESE_Q, 16'd1);
    query(`SRCC_CMD_ESR_Q, 16'd32);
    {qye_evt, dde_evt} = 2'h3;
    tick(1);
    {qye_evt, dde_evt} = 2'h0;
    query(`SRCC_CMD_ESR_Q, 16'd12);
    cmd(`SRCC_CMD_SRE, 16'd300, 1'b0, 1'b0);
    query(`SRCC_CMD_ESR_Q, 16'd16);
    qye_evt = 1'b1;
    tick(1);
    qye_evt = 1'b0;
    cmd(`SRCC_CMD_CLS, 16'd0, 1'b0, 1'b0);
    query(`SRCC_CMD_ESR_Q, 16'd0);
    cmd(`SRCC_CMD_ESE, 16'd9, 1'b0, 1'b0);
    cmd(`SRCC_CMD_RST, 16'd0, 1'b0, 1'b0);
    query(`SRCC_CMD_ESE_Q, 16'd0);
    query(`SRCC_CMD_ESR_Q, 16'd128);
    panel_srq = 1'b1;
    tick(6);
    chk(service_request_flag_q, 1'b1);
    panel_srq = 1'b0;
    tick(5);
    poll(8'h40);
    poll(8'h00);
    slow = 1'b1;
    cmd(`SRCC_CMD_IDN_Q, 16'd0, 1'b0, 1'b0);
    tick(3);
    chk(status_summary_byte_q, 8'h10);
    cmd(`SRCC_CMD_CLS, 16'd0, 1'b0, 1'b0);
    chk(status_summary_byte_q, 8'h10);
    cmd(`SRCC_CMD_CLS, 16'd0, 1'b0, 1'b1);
    tick(3);
    chk({resp_valid_q, status_summary_byte_q}, 9'h000);
    give_verdict;
  end
endmodule
